// file: rtl/vcwd_pkg.sv
/*
 package for the video capture write dma client: burst size, widths, states.
 assumes one 125 mhz clock domain (mclk) and a synchronous active-high reset.
*/
package vcwd_pkg;
   localparam int unsigned VCWD_BURST_BYTES = 128;
   localparam int unsigned VCWD_BURST_LOG2 = 7;
   localparam int unsigned VCWD_ADDR_W = 32;
   localparam int unsigned VCWD_LEN_W = 16;
   localparam int unsigned VCWD_LINES_W = 12;
   localparam int unsigned VCWD_NPLANE = 2;
   localparam logic [VCWD_BURST_LOG2-1:0] VCWD_REM_RESET = 7'h00;
   localparam logic [1:0] VCWD_DESC_NONE = 2'h0;
   typedef enum logic [1:0] {VCWD_IDLE, VCWD_BURST, VCWD_TAIL, VCWD_NEXT} vcwd_state_e;
endpackage : vcwd_pkg

// file: rtl/vcwd_client.sv
/*
 write-side capture dma client: burst splitting, tail transfer, per-plane ping-pong
 leftover state, current/shadow descriptor pair, 422 to 420 chroma line reduction.
 assumes the memory side answers each issued burst with wr_done, and the parser
 presents a whole line as a byte count (line_valid/line_bytes) before it is moved.
*/
`timescale 1ns/1ps
// Function
// - lines move to memory in fixed 128-byte bursts.
// - each line not a multiple of 128 bytes ends with one leftover transfer, then address steps by stride.
// - leftover size always comes from the same line being written.
// - leftover registers reset to zero; zero is never issued as burst size.
// - two leftover registers per channel, alternated line by line.
// - one-line first or second frame after reset or abort is handled correctly.
// - luma and chroma are separate streams with own line and leftover state.
// - 422 to 420 chroma of a two- or three-line frame becomes one line.
// - at most two descriptors held, current and shadow.
// - on completion shadow moves to current, shadow left empty.
// - a single descriptor sits in current only, never duplicated.
// - device never invents descriptors; only supplied ones direct writes.
module vcwd_client
   import vcwd_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic abort,
   input wire logic desc_valid,
   input wire logic [VCWD_ADDR_W-1:0] desc_base,
   input wire logic [VCWD_LEN_W-1:0] desc_stride,
   input wire logic [VCWD_LINES_W-1:0] desc_lines,
   output logic desc_ready,
   input wire logic chroma_420,
   input wire logic line_valid,
   input wire logic line_plane,
   input wire logic [VCWD_LEN_W-1:0] line_bytes,
   output logic line_ready,
   output logic wr_req,
   output logic [VCWD_ADDR_W-1:0] wr_addr,
   output logic [VCWD_BURST_LOG2:0] wr_size,
   output logic wr_plane,
   input wire logic wr_done,
   output logic frame_done,
   output logic [1:0] desc_count
);
   ////////////////////////////////////////////////////////////////////////
   typedef logic [VCWD_BURST_LOG2-1:0] vcwd_rem_t;
   vcwd_state_e state_q;
   logic cur_v_q, sh_v_q;
   logic [VCWD_ADDR_W-1:0] cur_base_q, sh_base_q;
   logic [VCWD_LEN_W-1:0] cur_stride_q, sh_stride_q;
   logic [VCWD_LINES_W-1:0] cur_lines_q, sh_lines_q;
   vcwd_rem_t rem_q [VCWD_NPLANE][2];
   logic pp_q [VCWD_NPLANE];
   logic [VCWD_LINES_W-1:0] lcnt_q [VCWD_NPLANE];
   logic [VCWD_ADDR_W-1:0] laddr_q [VCWD_NPLANE];
   logic [VCWD_LEN_W-VCWD_BURST_LOG2-1:0] bursts_q;
   logic [VCWD_ADDR_W-1:0] addr_q;
   logic pl_q;
   logic [VCWD_LINES_W-1:0] eff_lines;
   logic [VCWD_LINES_W-1:0] eff_lines_q;
   logic take_line, take_desc, done_line, frame_end;
   vcwd_rem_t new_rem;

   // chroma of a 420 frame with few lines collapses to one line
   always_comb
   begin
      eff_lines = cur_lines_q;
      if (chroma_420 && line_plane && cur_lines_q >= 12'h002 && cur_lines_q <= 12'h003)
      begin
         eff_lines = 12'h001;
      end
   end

   assign new_rem = line_bytes[VCWD_BURST_LOG2-1:0];
   // no descriptor, no line: writes only go where software pointed
   assign take_line = state_q == VCWD_IDLE && line_valid && cur_v_q && !abort;
   assign take_desc = desc_valid && !(cur_v_q && sh_v_q) && !abort;
   assign done_line = state_q == VCWD_NEXT;
   assign frame_end = done_line && lcnt_q[pl_q] + 12'h001 >= eff_lines_q;

   ////////////////////////////////////////////////////////////////////////
   // descriptor pair
   always_ff @(posedge mclk)
   begin
      if (rst || abort)
      begin
         cur_v_q <= 1'b0;
         sh_v_q <= 1'b0;
         cur_base_q <= '0;
         sh_base_q <= '0;
         cur_stride_q <= '0;
         sh_stride_q <= '0;
         cur_lines_q <= '0;
         sh_lines_q <= '0;
      end
      else
      begin
         if (frame_end && pl_q == 1'b1 || frame_end && !cur_v_q)
         begin
            // promote shadow, never copy current into shadow
            cur_v_q <= sh_v_q;
            cur_base_q <= sh_base_q;
            cur_stride_q <= sh_stride_q;
            cur_lines_q <= sh_lines_q;
            sh_v_q <= 1'b0;
            if (take_desc)
            begin
               if (sh_v_q)
               begin
                  sh_v_q <= 1'b1;
                  sh_base_q <= desc_base;
                  sh_stride_q <= desc_stride;
                  sh_lines_q <= desc_lines;
               end
               else
               begin
                  cur_v_q <= 1'b1;
                  cur_base_q <= desc_base;
                  cur_stride_q <= desc_stride;
                  cur_lines_q <= desc_lines;
               end
            end
         end
         else if (take_desc)
         begin
            if (!cur_v_q)
            begin
               cur_v_q <= 1'b1;
               cur_base_q <= desc_base;
               cur_stride_q <= desc_stride;
               cur_lines_q <= desc_lines;
            end
            else
            begin
               sh_v_q <= 1'b1;
               sh_base_q <= desc_base;
               sh_stride_q <= desc_stride;
               sh_lines_q <= desc_lines;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // line engine
   always_ff @(posedge mclk)
   begin
      if (rst || abort)
      begin
         state_q <= VCWD_IDLE;
         bursts_q <= '0;
         addr_q <= '0;
         pl_q <= 1'b0;
         eff_lines_q <= '0;
         wr_req <= 1'b0;
         wr_addr <= '0;
         wr_size <= '0;
         wr_plane <= 1'b0;
      end
      else
      begin
         case (state_q)
            VCWD_IDLE:
            begin
               if (take_line)
               begin
                  pl_q <= line_plane;
                  eff_lines_q <= eff_lines;
                  bursts_q <= line_bytes[VCWD_LEN_W-1:VCWD_BURST_LOG2];
                  addr_q <= (lcnt_q[line_plane] == '0) ? cur_base_q : laddr_q[line_plane];
                  state_q <= VCWD_BURST;
               end
            end
            VCWD_BURST:
            begin
               if (wr_req)
               begin
                  if (wr_done)
                  begin
                     wr_req <= 1'b0;
                     addr_q <= addr_q + VCWD_ADDR_W'(VCWD_BURST_BYTES);
                     bursts_q <= bursts_q - 1'b1;
                  end
               end
               else if (bursts_q != '0)
               begin
                  wr_req <= 1'b1;
                  wr_addr <= addr_q;
                  wr_size <= (VCWD_BURST_LOG2+1)'(VCWD_BURST_BYTES);
                  wr_plane <= pl_q;
               end
               else
               begin
                  state_q <= VCWD_TAIL;
               end
            end
            VCWD_TAIL:
            begin
               if (wr_req)
               begin
                  if (wr_done)
                  begin
                     wr_req <= 1'b0;
                     state_q <= VCWD_NEXT;
                  end
               end
               else if (rem_q[pl_q][pp_q[pl_q]] != VCWD_REM_RESET)
               begin
                  // size read from the slot just written for this line
                  wr_req <= 1'b1;
                  wr_addr <= addr_q;
                  wr_size <= {1'b0, rem_q[pl_q][pp_q[pl_q]]};
                  wr_plane <= pl_q;
               end
               else
               begin
                  state_q <= VCWD_NEXT;
               end
            end
            VCWD_NEXT:
            begin
               state_q <= VCWD_IDLE;
            end
            default:
            begin
               state_q <= VCWD_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-plane leftover ping-pong and line position; abort clears like reset
   always_ff @(posedge mclk)
   begin
      if (rst || abort)
      begin
         for (int p = 0; p < VCWD_NPLANE; p++)
         begin
            rem_q[p][0] <= VCWD_REM_RESET;
            rem_q[p][1] <= VCWD_REM_RESET;
            pp_q[p] <= 1'b0;
            lcnt_q[p] <= '0;
            laddr_q[p] <= '0;
         end
      end
      else
      begin
         if (take_line)
         begin
            // written before its own tail, so no stale value is ever sent
            pp_q[line_plane] <= ~pp_q[line_plane];
            rem_q[line_plane][~pp_q[line_plane]] <= new_rem;
         end
         if (done_line)
         begin
            if (frame_end)
            begin
               lcnt_q[pl_q] <= '0;
            end
            else
            begin
               lcnt_q[pl_q] <= lcnt_q[pl_q] + 12'h001;
               laddr_q[pl_q] <= ((lcnt_q[pl_q] == '0) ? cur_base_q : laddr_q[pl_q])
                  + VCWD_ADDR_W'(cur_stride_q);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk)
   begin
      if (rst || abort)
      begin
         desc_ready <= 1'b0;
         line_ready <= 1'b0;
         frame_done <= 1'b0;
         desc_count <= VCWD_DESC_NONE;
      end
      else
      begin
         desc_ready <= !(cur_v_q && sh_v_q) && !abort;
         line_ready <= take_line;
         frame_done <= frame_end;
         desc_count <= {1'b0, cur_v_q} + {1'b0, sh_v_q};
      end
   end
endmodule : vcwd_client

// file: test/vcwd_client_properties.sv
/*
 port checker for the capture write dma client.
 assumes one mclk domain and the bind below onto every vcwd_client.
*/
`timescale 1ns/1ps
module vcwd_client_properties
   import vcwd_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic abort,
   input wire logic desc_valid,
   input wire logic line_ready,
   input wire logic wr_req,
   input wire logic [VCWD_ADDR_W-1:0] wr_addr,
   input wire logic [VCWD_BURST_LOG2:0] wr_size,
   input wire logic wr_done,
   input wire logic [1:0] desc_count
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   a_size_nonzero: assert property (wr_req |-> wr_size != 8'h00)
      else $error("zero burst size issued");
   a_size_max: assert property (wr_req |-> wr_size <= 8'h80)
      else $error("burst size above 128");
   a_req_holds: assert property (
      wr_req && !wr_done && !abort |=> wr_req && $stable(wr_addr) && $stable(wr_size))
      else $error("burst request changed before done");
   a_done_drops: assert property (wr_req && wr_done |=> !wr_req)
      else $error("burst request kept after done");
   a_count_max: assert property (desc_count <= 2'h2)
      else $error("more than two descriptors held");
   a_no_invent: assert property (
      !desc_valid |=> ##1 (desc_count <= $past(desc_count)))
      else $error("descriptor count grew with nothing offered");
   a_reset_clear: assert property ($fell(rst) |-> !wr_req && desc_count == 2'h0)
      else $error("state left after reset");
   a_abort_clear: assert property (abort |=> !wr_req && desc_count == 2'h0)
      else $error("state left after abort");
   a_ready_pulse: assert property (line_ready |=> !line_ready)
      else $error("line accept pulse longer than one cycle");
   // covers: tail burst, full descriptor pair, abort in mid-burst
   c_tail: cover property (wr_req && wr_size < 8'h80);
   c_full: cover property (desc_count == 2'h2);
   c_abort: cover property (abort && wr_req);
endmodule : vcwd_client_properties
bind vcwd_client vcwd_client_properties u_props (.mclk(mclk), .rst(rst), .abort(abort),
   .desc_valid(desc_valid), .line_ready(line_ready), .wr_req(wr_req), .wr_addr(wr_addr),
   .wr_size(wr_size), .wr_done(wr_done), .desc_count(desc_count));

// file: test/vcwd_parser_model.sv
/*
 input parser stand-in: offers one whole line per go pulse.
 assumes the bench keeps frames legal; abort also flushes the source.
*/
`timescale 1ns/1ps
module vcwd_parser_model
   import vcwd_pkg::*;
(
   input wire logic mclk,
   input wire logic abort,
   input wire logic go,
   input wire logic go_plane,
   input wire logic [VCWD_LEN_W-1:0] go_bytes,
   input wire logic line_ready,
   output logic line_valid = 1'b0,
   output logic line_plane = 1'b0,
   output logic [VCWD_LEN_W-1:0] line_bytes = 16'h0
);
   // released count shows inverse, so a stale value never passes
   always @(posedge mclk)
   begin
      if (go)
      begin
         #1 line_valid = 1'b1;
         line_plane = go_plane;
         line_bytes = go_bytes;
      end
      else if (line_valid && (line_ready || abort))
      begin
         #1 line_valid = 1'b0;
         line_bytes = ~line_bytes;
      end
   end
endmodule : vcwd_parser_model

// file: test/test_vcwd_client.sv
/*
 self-checking bench for the capture write dma client.
 assumes the memory side is the responder below, with optional stall.
*/
`timescale 1ns/1ps
module test_vcwd_client
   import vcwd_pkg::*;
;
   logic mclk = 1'b0, rst = 1'b1, abort = 1'b0, desc_valid = 1'b0, chroma_420 = 1'b0;
   logic go = 1'b0, go_plane = 1'b0, wr_done = 1'b0, cur_p = 1'b0;
   logic [VCWD_ADDR_W-1:0] desc_base = 32'h0;
   logic [VCWD_LEN_W-1:0] desc_stride = 16'h0400, go_bytes = 16'h0;
   logic [VCWD_LINES_W-1:0] desc_lines = 12'h0;
   logic line_valid, line_plane, line_ready, wr_req, wr_plane, frame_done, desc_ready;
   logic [VCWD_LEN_W-1:0] line_bytes;
   logic [VCWD_ADDR_W-1:0] wr_addr;
   logic [VCWD_BURST_LOG2:0] wr_size;
   logic [1:0] desc_count;
   logic [31:0] ad_q[$], sz_q[$];
   int n_mismatch = 0, total_checks = 0, slow = 0, wait_n = 0, frames = 0;
   always #4 mclk = ~mclk;
   always @(posedge mclk)
      if (frame_done === 1'b1)
         frames++;
   vcwd_client u_dut (.mclk(mclk), .rst(rst), .abort(abort), .desc_valid(desc_valid),
      .desc_base(desc_base), .desc_stride(desc_stride), .desc_lines(desc_lines),
      .desc_ready(desc_ready), .chroma_420(chroma_420), .line_valid(line_valid),
      .line_plane(line_plane), .line_bytes(line_bytes), .line_ready(line_ready),
      .wr_req(wr_req), .wr_addr(wr_addr), .wr_size(wr_size), .wr_plane(wr_plane),
      .wr_done(wr_done), .frame_done(frame_done), .desc_count(desc_count));
   vcwd_parser_model u_src (.mclk(mclk), .abort(abort), .go(go), .go_plane(go_plane),
      .go_bytes(go_bytes), .line_ready(line_ready), .line_valid(line_valid),
      .line_plane(line_plane), .line_bytes(line_bytes));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test;
      if (n_mismatch == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   // memory side: stalls slow cycles, then one done pulse per burst
   always @(posedge mclk)
   begin
      if (wr_req === 1'b1 && !wr_done)
      begin
         if (wait_n < slow)
            wait_n++;
         else
         begin
            sz_q.push_back(32'(wr_size));
            ad_q.push_back(wr_addr);
            chk(wr_plane, cur_p);
            wait_n = 0;
            #1 wr_done = 1'b1;
         end
      end
      else if (wr_done)
         #1 wr_done = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_desc(input logic [31:0] b, input logic [11:0] n, input logic [1:0] e);
      desc_valid = 1'b1;
      desc_base = b;
      desc_lines = n;
      tick(1);
      desc_valid = 1'b0;
      tick(1);
      chk(desc_count, e);
      chk(desc_ready, e != 2'h2);
   endtask : give_desc
   task automatic send_line(input logic p, input logic [15:0] b);
      cur_p = p;
      go = 1'b1;
      go_plane = p;
      go_bytes = b;
      tick(1);
      go = 1'b0;
   endtask : send_line
   task automatic expect_line(input logic p, input logic [15:0] b, input logic [31:0] a0);
      int n, i;
      n = b / 128 + ((b % 128) != 0);
      for (i = 0; i < 400 && sz_q.size() < n; i++)
         tick(1);
      if (i == 400)
      begin
         n_mismatch++;
         end_of_test();
      end
      tick(8);
      chk(sz_q.size(), n);
      for (i = 0; i < n; i++)
      begin
         chk(sz_q[i], (i < n - 1 || b % 128 == 0) ? 128 : b % 128);
         chk(ad_q[i], a0 + 128 * i);
      end
      sz_q.delete();
      ad_q.delete();
   endtask : expect_line
   task automatic line(input logic p, input logic [15:0] b, input logic [31:0] a0);
      send_line(p, b);
      expect_line(p, b, a0);
   endtask : line
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_first_frames;
      give_desc(32'h1000, 12'h1, 2'h1);
      give_desc(32'h8000, 12'h1, 2'h2);
      give_desc(32'hf000, 12'h1, 2'h2);
      // one-line frames on purpose, below the source's line floor
      line(1'b0, 16'd300, 32'h1000);
      line(1'b1, 16'd200, 32'h1000);
      chk(desc_count, 2'h1);
      line(1'b0, 16'd256, 32'h8000);
      line(1'b1, 16'd1, 32'h8000);
      chk(desc_count, 2'h0);
      chk(frames, 4);
   endtask : t_first_frames
   task automatic t_wait_420;
      slow = 2;
      chroma_420 = 1'b1;
      send_line(1'b0, 16'd130);
      tick(20);
      chk(sz_q.size(), 0);
      give_desc(32'h2000, 12'h2, 2'h1);
      expect_line(1'b0, 16'd130, 32'h2000);
      line(1'b0, 16'd64, 32'h2400);
      line(1'b1, 16'd65, 32'h2000);
      chk(desc_count, 2'h0);
      chk(frames, 6);
      chroma_420 = 1'b0;
      slow = 0;
   endtask : t_wait_420
   task automatic t_abort;
      give_desc(32'h3000, 12'h1, 2'h1);
      send_line(1'b0, 16'd1000);
      tick(10);
      abort = 1'b1;
      tick(1);
      abort = 1'b0;
      tick(4);
      chk(desc_count, 2'h0);
      chk(wr_req, 1'b0);
      sz_q.delete();
      ad_q.delete();
      give_desc(32'h4000, 12'h1, 2'h1);
      line(1'b0, 16'd129, 32'h4000);
      line(1'b1, 16'd3, 32'h4000);
      chk(frames, 8);
   endtask : t_abort
   initial
   begin
      tick(5);
      rst = 1'b0;
      tick(1);
      chk(wr_req, 1'b0);
      chk(desc_count, 2'h0);
      t_first_frames();
      t_wait_420();
      t_abort();
      end_of_test();
   end
endmodule : test_vcwd_client
